// ===== hw/lms_defs.svh
// Offsets, field positions, reset values and timing counts of the linked motion sequencer
`ifndef LMS_DEFS_SVH
`define LMS_DEFS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LMS_OFS_CTRL 8'h00
`define LMS_OFS_STATUS 8'h04
`define LMS_OFS_INT_STAT 8'h08
`define LMS_OFS_INT_CLR 8'h0C
`define LMS_OFS_INT_EN 8'h10
`define LMS_OFS_TAB_IDX 8'h14
`define LMS_OFS_TAB_DATA 8'h18
// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define LMS_CTRL_EN 0
`define LMS_CTRL_ALM_CLR 1
`define LMS_CTRL_RST 32'h0000_0001
`define LMS_ST_READY 0
`define LMS_ST_MOVING 1
`define LMS_ST_ALARM 2
`define LMS_ST_DWELL 3
`define LMS_ST_CUR_LSB 8
`define LMS_INT_DONE 0
`define LMS_INT_ALARM 1
`define LMS_INT_STAGE 2
`define LMS_INT_W 3
// ----------------------------------------
// Entry word layout and function codes
// ----------------------------------------
`define LMS_E_FUNC_LSB 0
`define LMS_E_DIR 2
`define LMS_E_ACC_LSB 4
`define LMS_E_DEC_LSB 8
`define LMS_E_DWELL_LSB 12
`define LMS_FUNC_SINGLE 2'h0
`define LMS_FUNC_LINK 2'h1
`define LMS_FUNC_LINK2 2'h2
`define LMS_LAST_ENTRY 6'h3F
`define LMS_MAX_CHAIN 4
// ----------------------------------------
// Timing
// ----------------------------------------
`define LMS_CLK_NS 40
`define LMS_MS_NS 1000000
`define LMS_MS_CYCLES (`LMS_MS_NS / `LMS_CLK_NS)
`endif

// ===== hw/lms_pkg.sv
// Types shared by the linked motion sequencer
package lms_pkg;
  typedef enum logic [1:0] {LMS_IDLE, LMS_RUN, LMS_DWELL} lms_state_e;
  typedef logic [5:0] lms_idx_t;
endpackage : lms_pkg

// ===== hw/lms_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module lms_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta[g] <= 1'b0;
          dout[g] <= 1'b0;
        end
        else
        begin
          meta[g] <= din[g];
          dout[g] <= meta[g];
        end
      end
    end
  endgenerate
endmodule : lms_sync

// ===== hw/lms_dwell_timer.sv
// Millisecond dwell timer with load and expiry pulse
`timescale 1ns/100ps
module lms_dwell_timer #(
  parameter int MS_CYCLES = 25000,
  parameter int DW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [DW-1:0] load_ms,
  output logic active,
  output logic expired
);
  logic [DW-1:0] remain;
  logic [31:0] pre;
  wire logic pre_wrap = (pre == 32'(MS_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active <= 1'b0;
      expired <= 1'b0;
      remain <= '0;
      pre <= 32'h0000_0000;
    end
    else if (load)
    begin
      active <= 1'b1;
      expired <= 1'b0;
      remain <= load_ms;
      pre <= 32'h0000_0000;
    end
    else
    begin
      expired <= active && (remain == '0);
      if (active && (remain == '0))
        active <= 1'b0;
      else if (active && pre_wrap)
      begin
        pre <= 32'h0000_0000;
        remain <= remain - 1'b1;
      end
      else if (active)
        pre <= pre + 32'h0000_0001;
    end
  end
endmodule : lms_dwell_timer

// ===== hw/lms_sequencer.sv
// Linked motion sequencer with APB register file and entry table
//
// Summary of operation
// R1: A plain linked entry hands over to the next entry number with no stop in between.
// R2: A chain ends at the first single-motion entry, and the motor stops after it.
// R3: A chain holds at most four entries, and plain linked entries share one direction.
// R4: Plain linked entries of differing direction raise the operation data alarm while running.
// R5: Five or more chained entries of either linked kind raise the alarm at start.
// R6: The last entry never links onward to entry zero and runs on its own.
// R7: A plain linked chain keeps the acceleration and deceleration of its first entry.
// R8: A second-kind linked entry lets the next entry turn the other way.
// R9: After a second-kind linked entry the motor stops, dwells, then starts the next entry itself.
// R10: Moving drops when a stage before a dwell ends and rises as the next stage starts.
// R11: The host checks ready, sets the entry number on the select inputs, then raises start.
// R12: Ready drops as the operation begins, and the host waits for that before releasing start.
// R13: Ready returns only after the last entry of the whole chain has finished.
// R14: Dwell is counted in milliseconds from the system clock, loaded when the stage ends.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`include "lms_defs.svh"
module lms_sequencer
  import lms_pkg::*;
#(
  parameter int MS_CYCLES = `LMS_MS_CYCLES,
  parameter int ENTRIES = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] data_select_inputs,
  input wire logic start_in,
  output logic ready,
  output logic moving,
  output logic alarm,
  output logic irq,
  output logic stage_start,
  output logic [5:0] stage_entry,
  output logic stage_dir,
  output logic [3:0] stage_accel,
  output logic [3:0] stage_decel,
  output logic stage_no_stop,
  input wire logic stage_done
);
  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  logic [31:0] table_mem [ENTRIES];
  logic [31:0] ctrl;
  logic [`LMS_INT_W-1:0] int_stat;
  logic [`LMS_INT_W-1:0] int_en;
  lms_idx_t tab_idx;
  lms_state_e state;
  lms_idx_t cur;
  logic start_prev;
  logic ev_done;
  logic ev_alarm;
  logic ev_stage;
  logic [5:0] sel_sync;
  logic start_sync;
  logic dwell_expired;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  lms_sync #(.W(7)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({start_in, data_select_inputs}),
    .dout({start_sync, sel_sync})
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire logic setup = psel && !penable;
  wire logic wr_acc = psel && penable && pwrite;
  wire logic hit_ctrl = (paddr == `LMS_OFS_CTRL);
  wire logic hit_status = (paddr == `LMS_OFS_STATUS);
  wire logic hit_istat = (paddr == `LMS_OFS_INT_STAT);
  wire logic hit_iclr = (paddr == `LMS_OFS_INT_CLR);
  wire logic hit_ien = (paddr == `LMS_OFS_INT_EN);
  wire logic hit_tidx = (paddr == `LMS_OFS_TAB_IDX);
  wire logic hit_tdata = (paddr == `LMS_OFS_TAB_DATA);
  wire logic hit_any = hit_ctrl || hit_status || hit_istat || hit_iclr || hit_ien || hit_tidx || hit_tdata;
  wire logic [31:0] bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire logic [31:0] wr_ctrl = (ctrl & ~bmask) | (pwdata & bmask);
  wire logic [31:0] wr_tab = (table_mem[tab_idx] & ~bmask) | (pwdata & bmask);
  wire logic alm_clr = wr_acc && hit_ctrl && pstrb[0] && pwdata[`LMS_CTRL_ALM_CLR];
  wire logic [`LMS_INT_W-1:0] iclr = (wr_acc && hit_iclr && pstrb[0]) ? pwdata[`LMS_INT_W-1:0] : '0;
  wire logic enable = ctrl[`LMS_CTRL_EN];

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // ----------------------------------------
  // Chain walk from the selected entry
  // ----------------------------------------
  lms_idx_t walk_idx [`LMS_MAX_CHAIN];
  logic [`LMS_MAX_CHAIN-1:0] walk_self;
  logic [`LMS_MAX_CHAIN-1:0] walk_link;

  // R3: four entry limit
  genvar k;
  generate
    for (k = 0; k < `LMS_MAX_CHAIN; k++)
    begin : g_walk
      assign walk_idx[k] = sel_sync + 6'(k);
      // R6: last entry
      assign walk_self[k] = (table_mem[walk_idx[k]][`LMS_E_FUNC_LSB+:2] != `LMS_FUNC_SINGLE)
        && (walk_idx[k] != `LMS_LAST_ENTRY);
      if (k == 0)
      begin : g_head
        assign walk_link[k] = walk_self[k];
      end
      else
      begin : g_tail
        assign walk_link[k] = walk_self[k] && walk_link[k-1];
      end
    end
  endgenerate

  // R5: length check
  wire logic too_long = walk_link[`LMS_MAX_CHAIN-1];

  // ----------------------------------------
  // Current and next entry fields
  // ----------------------------------------
  wire lms_idx_t nxt = cur + 6'h01;
  wire logic [31:0] cur_e = table_mem[cur];
  wire logic [31:0] nxt_e = table_mem[nxt];
  wire logic [31:0] sel_e = table_mem[sel_sync];
  wire logic [1:0] cur_func = cur_e[`LMS_E_FUNC_LSB+:2];
  // R6: no wrap
  wire logic cur_links = (cur_func != `LMS_FUNC_SINGLE) && (cur != `LMS_LAST_ENTRY);
  wire logic cur_plain = cur_links && (cur_func == `LMS_FUNC_LINK);
  // R4: direction clash
  wire logic dir_clash = cur_plain && (nxt_e[`LMS_E_DIR] != cur_e[`LMS_E_DIR]);
  wire logic nxt_plain = (nxt_e[1:0] == `LMS_FUNC_LINK) && (nxt != `LMS_LAST_ENTRY);
  wire logic sel_plain = (sel_e[1:0] == `LMS_FUNC_LINK) && (sel_sync != `LMS_LAST_ENTRY);

  // R11: start edge
  wire logic start_edge = start_sync && !start_prev;
  wire logic idle = (state == LMS_IDLE);
  wire logic take = idle && start_edge && enable && !alarm;
  wire logic launch = take && !too_long;
  wire logic run_done = (state == LMS_RUN) && stage_done;
  // R2: chain end
  wire logic chain_end = run_done && !cur_links;
  wire logic clash_stop = run_done && dir_clash;
  // R1: direct handover
  wire logic hop_plain = run_done && cur_plain && !dir_clash;
  // R9: enter dwell
  wire logic hop_dwell = run_done && cur_links && !cur_plain;
  wire logic dwell_go = (state == LMS_DWELL) && dwell_expired;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  lms_state_e next_state;
  always_comb
  begin
    next_state = state;
    unique case (state)
      LMS_IDLE:
        if (launch)
          next_state = LMS_RUN;
      LMS_RUN:
        if (chain_end || clash_stop)
          next_state = LMS_IDLE;
        else if (hop_dwell)
          next_state = LMS_DWELL;
      LMS_DWELL:
        if (dwell_go)
          next_state = LMS_RUN;
    endcase
  end

  // ----------------------------------------
  // Dwell timer
  // ----------------------------------------
  // R14: millisecond dwell
  lms_dwell_timer #(.MS_CYCLES(MS_CYCLES), .DW(16)) u_dwell (
    .pclk(pclk),
    .presetn(presetn),
    .load(hop_dwell),
    .load_ms(cur_e[`LMS_E_DWELL_LSB+:16]),
    .active(),
    .expired(dwell_expired)
  );

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= LMS_IDLE;
      cur <= '0;
      start_prev <= 1'b0;
    end
    else
    begin
      state <= next_state;
      start_prev <= start_sync;
      if (take)
        cur <= sel_sync;
      else if (hop_plain || dwell_go)
        cur <= nxt;
    end
  end

  // R12: ready drops
  // R13: ready after chain
  assign ready = idle && enable && !alarm;
  // R10: moving while running
  assign moving = (state == LMS_RUN);

  // ----------------------------------------
  // Stage command to the motion engine
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_start <= 1'b0;
      stage_entry <= '0;
      stage_dir <= 1'b0;
      stage_accel <= '0;
      stage_decel <= '0;
      stage_no_stop <= 1'b0;
    end
    else
    begin
      // R1: launch or hand over
      stage_start <= launch || hop_plain || dwell_go;
      if (launch)
      begin
        stage_entry <= sel_sync;
        stage_dir <= sel_e[`LMS_E_DIR];
        stage_accel <= sel_e[`LMS_E_ACC_LSB+:4];
        stage_decel <= sel_e[`LMS_E_DEC_LSB+:4];
        stage_no_stop <= sel_plain;
      end
      // R7: keep first ramp
      else if (hop_plain)
      begin
        stage_entry <= nxt;
        stage_dir <= nxt_e[`LMS_E_DIR];
        stage_no_stop <= nxt_plain;
      end
      // R8: new direction allowed
      else if (dwell_go)
      begin
        stage_entry <= nxt;
        stage_dir <= nxt_e[`LMS_E_DIR];
        stage_accel <= nxt_e[`LMS_E_ACC_LSB+:4];
        stage_decel <= nxt_e[`LMS_E_DEC_LSB+:4];
        stage_no_stop <= nxt_plain;
      end
    end
  end

  // ----------------------------------------
  // Alarm and interrupt status
  // ----------------------------------------
  // R4 R5: alarm events
  assign ev_alarm = (take && too_long) || clash_stop;
  assign ev_done = chain_end;
  assign ev_stage = run_done;
  wire logic [`LMS_INT_W-1:0] ev_vec = {ev_stage, ev_alarm, ev_done};
  wire logic [`LMS_INT_W-1:0] next_int_stat = ev_vec | (int_stat & ~iclr);
  wire logic next_alarm = ev_alarm || (alarm && !alm_clr);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alarm <= 1'b0;
      int_stat <= '0;
      irq <= 1'b0;
    end
    else
    begin
      alarm <= next_alarm;
      int_stat <= next_int_stat;
      irq <= |(next_int_stat & int_en);
    end
  end

  // ----------------------------------------
  // Software registers and entry table
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `LMS_CTRL_RST;
      int_en <= '0;
      tab_idx <= '0;
    end
    else if (wr_acc)
    begin
      if (hit_ctrl)
        ctrl <= {30'h0000_0000, 1'b0, wr_ctrl[`LMS_CTRL_EN]};
      if (hit_ien && pstrb[0])
        int_en <= pwdata[`LMS_INT_W-1:0];
      if (hit_tidx && pstrb[0])
        tab_idx <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk)
  begin
    if (wr_acc && hit_tdata)
      table_mem[tab_idx] <= wr_tab;
  end

  // ----------------------------------------
  // Read data, captured in the setup phase
  // ----------------------------------------
  wire logic dwelling = (state == LMS_DWELL);
  wire logic [31:0] st_word = {18'h0_0000, cur, 4'h0, dwelling, alarm, moving, ready};
  wire logic [31:0] rd_mux =
    hit_ctrl ? ctrl :
    hit_status ? st_word :
    hit_istat ? {29'h0000_0000, int_stat} :
    hit_ien ? {29'h0000_0000, int_en} :
    hit_tidx ? {26'h000_0000, tab_idx} :
    hit_tdata ? table_mem[tab_idx] : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rd_mux;
  end
endmodule : lms_sequencer

// ===== bench/lms_seq_props.sv
// Concurrent checks on the sequencer pins
`timescale 1ns/100ps
`include "lms_defs.svh"
module lms_seq_props
  import lms_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ready,
  input wire logic moving,
  input wire logic alarm,
  input wire logic stage_start,
  input wire logic [5:0] stage_entry,
  input wire logic stage_dir,
  input wire logic [3:0] stage_accel,
  input wire logic [3:0] stage_decel,
  input wire logic stage_no_stop,
  input wire logic stage_done
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------
  // Stage handover
  // ----------------
  a_stage_busy: assert property (stage_start |-> !ready && moving)
    else $error("stage start while ready");
  a_link_next: assert property (stage_done && stage_no_stop |=> alarm ||
    (stage_start && stage_entry == $past(stage_entry) + 6'h01))
    else $error("no direct handover");
  a_keep_ramp: assert property (stage_done && stage_no_stop ##1 stage_start |->
    stage_accel == $past(stage_accel) && stage_decel == $past(stage_decel))
    else $error("ramp changed in chain");
  a_same_dir: assert property (stage_done && stage_no_stop ##1 stage_start |-> stage_dir == $past(stage_dir))
    else $error("direction changed in chain");
  a_stop_drop: assert property (stage_done && !stage_no_stop |=> !moving)
    else $error("moving held after stop");
  a_busy_low: assert property (moving |-> !ready)
    else $error("ready while moving");
  a_dwell_go: assert property ($fell(moving) && !ready && !alarm |-> ##[1:1000] stage_start && moving)
    else $error("no restart after dwell");
  a_alarm_halt: assert property (alarm |-> !stage_start)
    else $error("stage under alarm");
  a_last_alone: assert property (stage_done && stage_entry == `LMS_LAST_ENTRY |=> !moving && !stage_start)
    else $error("last entry linked on");
  c_link: cover property (stage_done && stage_no_stop ##1 stage_start);
  c_dwell: cover property ($fell(moving) && !ready && !alarm);
  c_alarm: cover property ($rose(alarm));
endmodule : lms_seq_props

bind lms_sequencer lms_seq_props u_props (.pclk(pclk), .presetn(presetn), .ready(ready), .moving(moving),
  .alarm(alarm), .stage_start(stage_start), .stage_entry(stage_entry), .stage_dir(stage_dir),
  .stage_accel(stage_accel), .stage_decel(stage_decel), .stage_no_stop(stage_no_stop), .stage_done(stage_done));

// ===== bench/lms_host_model.sv
// Host and motion engine model at the sequencer pins
`timescale 1ns/100ps
module lms_host_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic [5:0] sel_req,
  input wire logic [7:0] lat,
  input wire logic ready,
  input wire logic moving,
  input wire logic stage_start,
  output logic [5:0] data_select_inputs,
  output logic start_in,
  output logic stage_done
);
  // ----------------
  // Start handshake
  // ----------------
  initial
  begin
    start_in = 1'b0;
    data_select_inputs = 6'h15;
    forever
    begin
      @(posedge pclk);
      if (go && ready === 1'b1)
      begin
        data_select_inputs <= sel_req;
        @(posedge pclk);
        start_in <= 1'b1;
        while (ready !== 1'b0) @(posedge pclk);
        start_in <= 1'b0;
        data_select_inputs <= ~sel_req;
      end
    end
  end
  // ----------------
  // Motion engine
  // ----------------
  initial
  begin
    stage_done = 1'b0;
    forever
    begin
      @(posedge pclk);
      if (stage_start === 1'b1)
      begin
        repeat (lat) @(posedge pclk);
        stage_done <= moving;
        @(posedge pclk);
        stage_done <= 1'b0;
      end
    end
  end
endmodule : lms_host_model

// ===== bench/testbench.sv
// Self-checking testbench of the sequencer
`timescale 1ns/100ps
`include "lms_defs.svh"
module testbench;
  import lms_pkg::*;
  localparam int MS = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, err;
  logic [7:0] paddr, lat;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, stage_accel, stage_decel;
  logic [5:0] data_select_inputs, stage_entry, sel_req;
  logic start_in, ready, moving, alarm, irq, stage_start, stage_dir, stage_no_stop, stage_done;
  integer failures = 0, n_tests = 0, cyc = 0, done_at = 0, gap = 0;
  logic [5:0] ent_q[$];
  logic [3:0] acc_q[$];
  logic dir_q[$];
  lms_sequencer #(.MS_CYCLES(MS), .ENTRIES(64)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .data_select_inputs(data_select_inputs), .start_in(start_in),
    .ready(ready), .moving(moving), .alarm(alarm), .irq(irq), .stage_start(stage_start),
    .stage_entry(stage_entry), .stage_dir(stage_dir), .stage_accel(stage_accel),
    .stage_decel(stage_decel), .stage_no_stop(stage_no_stop), .stage_done(stage_done));
  lms_host_model partner (.pclk(pclk), .go(go), .sel_req(sel_req), .lat(lat), .ready(ready),
    .moving(moving), .stage_start(stage_start), .data_select_inputs(data_select_inputs),
    .start_in(start_in), .stage_done(stage_done));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (stage_done === 1'b1) done_at <= cyc;
    if (stage_start === 1'b1)
    begin
      ent_q.push_back(stage_entry);
      acc_q.push_back(stage_accel);
      dir_q.push_back(stage_dir);
      gap <= cyc - done_at;
    end
  end
  // ----------------
  // Shared tasks
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    integer k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (k = 0; pready !== 1'b1 && k < 50; k++) @(posedge pclk);
    chk({31'h0, pready}, 32'h1, "pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr_ent(input logic [5:0] i, input logic [1:0] fn, input logic dir, input logic [3:0] acc,
    input logic [15:0] dw);
    apb(`LMS_OFS_TAB_IDX, 1'b1, {26'h0, i});
    apb(`LMS_OFS_TAB_DATA, 1'b1, {4'h0, dw, acc, acc, 1'b0, dir, fn});
  endtask : wr_ent
  task automatic run(input logic [5:0] s, input logic [7:0] l);
    integer k;
    ent_q.delete();
    acc_q.delete();
    dir_q.delete();
    lat <= l;
    sel_req <= s;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (k = 0; ready === 1'b1 && k < 50; k++) @(posedge pclk);
    chk({31'h0, k < 50}, 32'h1, "start taken");
    for (k = 0; ready !== 1'b1 && alarm !== 1'b1 && k < 3000; k++) @(posedge pclk);
    chk({31'h0, k < 3000}, 32'h1, "chain over");
    repeat (4) @(posedge pclk);
  endtask : run
  task automatic clr_alm();
    apb(`LMS_OFS_CTRL, 1'b1, 32'h3);
    apb(`LMS_OFS_STATUS, 1'b0, 32'h0);
    chk({31'h0, alarm}, 32'h0, "alarm clear");
    chk({30'h0, rd[`LMS_ST_ALARM], rd[`LMS_ST_READY]}, 32'h1, "status");
  endtask : clr_alm
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_regs();
    apb(`LMS_OFS_CTRL, 1'b0, 32'h0);
    chk(rd, `LMS_CTRL_RST, "ctrl reset");
    pstrb <= 4'h2;
    apb(`LMS_OFS_CTRL, 1'b1, 32'h0);
    pstrb <= 4'hF;
    apb(`LMS_OFS_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h1, "strobe mask");
    apb(`LMS_OFS_CTRL, 1'b1, 32'h0);
    @(posedge pclk);
    chk({31'h0, ready}, 32'h0, "disabled");
    apb(`LMS_OFS_CTRL, 1'b1, 32'h1);
    apb(8'h40, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    $display("test regs done");
  endtask : t_regs
  task automatic t_link();
    wr_ent(6'h01, `LMS_FUNC_LINK, 1'b0, 4'h3, 16'h0000);
    wr_ent(6'h02, `LMS_FUNC_LINK, 1'b0, 4'h7, 16'h0000);
    wr_ent(6'h03, `LMS_FUNC_LINK, 1'b0, 4'h9, 16'h0000);
    wr_ent(6'h04, `LMS_FUNC_SINGLE, 1'b0, 4'h1, 16'h0000);
    apb(`LMS_OFS_INT_EN, 1'b1, 32'h1);
    run(6'h01, 8'h05);
    chk(32'(ent_q.size()), 32'h4, "chain size");
    for (int i = 0; i < 4; i++)
    begin
      chk({26'h0, ent_q[i]}, 32'(i + 1), "entry");
      chk({28'h0, acc_q[i]}, 32'h3, "accel");
    end
    chk({29'h0, moving, ready, irq}, 32'h3, "chain end");
    chk({28'h0, stage_decel}, 32'h3, "decel");
    chk({31'h0, stage_no_stop}, 32'h0, "last stops");
    apb(`LMS_OFS_INT_EN, 1'b1, 32'h0);
    apb(`LMS_OFS_INT_STAT, 1'b0, 32'h0);
    chk({30'h0, rd[0], irq}, 32'h2, "masked");
    apb(`LMS_OFS_INT_CLR, 1'b1, 32'h7);
    apb(`LMS_OFS_INT_EN, 1'b1, 32'h1);
    apb(`LMS_OFS_INT_STAT, 1'b0, 32'h0);
    chk({30'h0, rd[0], irq}, 32'h0, "cleared");
    $display("test link done");
  endtask : t_link
  task automatic t_dwell();
    wr_ent(6'h05, `LMS_FUNC_LINK2, 1'b0, 4'h2, 16'h0001);
    wr_ent(6'h06, `LMS_FUNC_SINGLE, 1'b1, 4'h4, 16'h0000);
    run(6'h05, 8'h01);
    chk(32'(ent_q.size()), 32'h2, "auto restart");
    chk({31'h0, dir_q[1]}, 32'h1, "reversed");
    chk({28'h0, acc_q[1]}, 32'h4, "own ramp");
    chk({31'h0, gap >= MS + 1 && gap <= MS + 4}, 32'h1, "dwell span");
    $display("test dwell done");
  endtask : t_dwell
  task automatic t_dir();
    wr_ent(6'h0A, `LMS_FUNC_LINK, 1'b0, 4'h2, 16'h0000);
    wr_ent(6'h0B, `LMS_FUNC_SINGLE, 1'b1, 4'h2, 16'h0000);
    run(6'h0A, 8'h02);
    chk({31'h0, alarm}, 32'h1, "reversal alarm");
    chk(32'(ent_q.size()), 32'h1, "stop at clash");
    clr_alm();
    $display("test dir done");
  endtask : t_dir
  task automatic t_long();
    for (int i = 20; i < 24; i++)
      wr_ent(6'(i), (i == 22) ? `LMS_FUNC_LINK2 : `LMS_FUNC_LINK, 1'b0, 4'h2, 16'h0000);
    wr_ent(6'h18, `LMS_FUNC_SINGLE, 1'b0, 4'h2, 16'h0000);
    run(6'h14, 8'h01);
    chk({31'h0, alarm}, 32'h1, "five alarm");
    chk(32'(ent_q.size()), 32'h0, "no stage");
    clr_alm();
    $display("test long done");
  endtask : t_long
  task automatic t_last();
    wr_ent(6'h3F, `LMS_FUNC_LINK, 1'b0, 4'h2, 16'h0000);
    wr_ent(6'h00, `LMS_FUNC_LINK, 1'b1, 4'h2, 16'h0000);
    run(6'h3F, 8'h02);
    chk({31'h0, alarm}, 32'h0, "alone");
    chk(32'(ent_q.size()), 32'h1, "one stage");
    chk({31'h0, ready}, 32'h1, "ready");
    $display("test last done");
  endtask : t_last
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, go, paddr, pwdata, sel_req} = '0;
    pstrb = 4'hF;
    lat = 8'h01;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_link();
    t_dwell();
    t_dir();
    t_long();
    t_last();
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    give_verdict();
  end
endmodule : testbench
